//--- rtl/bus_control_flags.sv
// bus engagement, repeated start, acknowledge and fault flags with ahb slave
`timescale 1ns/1ps
`default_nettype none
module bus_control_flags (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire bus_control_pkg::unit_status_t unit_status,
  output bus_control_pkg::engine_req_t engine_req,
  output logic controller_select,
  output logic cond_irq,
  output logic transfer_irq
);
  bus_control_pkg::bus_phase_t phase_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_lvl_reg;
  logic sda_lvl_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [3:0] bit_cnt_reg;
  logic first_byte_reg;
  logic bus_busy_reg;
  logic nack_reg;
  logic ack_slot_reg;
  logic rs_pending_reg;
  logic cs_reg;
  logic engaged_reg;
  logic ack_en_reg;
  logic stall_reg;
  logic cond_en_reg;
  logic int_en_reg;
  logic fault_reg;
  logic event_reg;
  logic event_by_fault_reg;
  logic stop_seen_reg;
  logic rs_seen_reg;
  bus_control_pkg::unit_cfg_t cfg_reg;
  bus_control_pkg::engine_req_t req_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic ev8;
  logic ev9;
  logic wr_ctl;
  logic wr_stat;
  logic wr_cfg;
  logic [7:0] wd;
  logic rs_go;
  logic rs_clr;
  logic stop_go;
  logic fault_set;
  logic stall_eff;
  logic event_set;
  logic event_clr;
  logic reserved_first;
  logic receiving;
  logic ack_now;
  logic [7:0] ctl_rd;

  // ahb slave: writes land at data phase, reads take one wait state
  assign hresp = 1'b0;
  assign hreadyout = (phase_reg != bus_control_pkg::PH_READ);
  assign hrdata = hrdata_reg;
  assign wd = hwdata[7:0];
  assign wr_ctl = (phase_reg == bus_control_pkg::PH_WRITE) &&
                  (addr_reg == bus_control_pkg::OFF_BUS_CONTROL);
  assign wr_stat = (phase_reg == bus_control_pkg::PH_WRITE) &&
                   (addr_reg == bus_control_pkg::OFF_COND_STATUS);
  assign wr_cfg = (phase_reg == bus_control_pkg::PH_WRITE) &&
                  (addr_reg == bus_control_pkg::OFF_UNIT_CONFIG);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      phase_reg <= bus_control_pkg::PH_IDLE;
      addr_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      case (phase_reg)
        bus_control_pkg::PH_READ:
          phase_reg <= bus_control_pkg::PH_READ_OUT;
        default:
        begin
          if (hsel && hready && (htrans == bus_control_pkg::HTRANS_NONSEQ))
          begin
            phase_reg <= hwrite ? bus_control_pkg::PH_WRITE :
                                  bus_control_pkg::PH_READ;
            addr_reg <= {haddr[7:2], 2'b00};
          end
          else
          begin
            phase_reg <= bus_control_pkg::PH_IDLE;
          end
        end
      endcase
    end
  end

  // shared bit reads the engagement flag
  assign ctl_rd = {cs_reg, engaged_reg, ack_en_reg, stall_reg, cond_en_reg,
                   int_en_reg, fault_reg, event_reg};

  always_ff @(posedge clk)
  begin
    if (!nrst)
      hrdata_reg <= 32'h0000_0000;
    else if (clk_en && (phase_reg == bus_control_pkg::PH_READ))
    begin
      case (addr_reg)
        bus_control_pkg::OFF_BUS_CONTROL: hrdata_reg <= {24'h00_0000, ctl_rd};
        bus_control_pkg::OFF_COND_STATUS:
          hrdata_reg <= {29'h0, bus_busy_reg, rs_seen_reg,
                         stop_seen_reg};
        bus_control_pkg::OFF_UNIT_CONFIG:
          hrdata_reg <= {28'h000_0000, cfg_reg};
        default: hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // pins are asynchronous: three stages, a level counts once two agree
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_lvl_reg <= 1'b1;
      sda_lvl_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_lvl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_lvl_reg <= sda_sync_reg[2];
      scl_prev_reg <= scl_lvl_reg;
      sda_prev_reg <= sda_lvl_reg;
    end
  end

  assign scl_rise = scl_lvl_reg && !scl_prev_reg;
  assign scl_fall = !scl_lvl_reg && scl_prev_reg;
  assign start_det = scl_lvl_reg && scl_prev_reg && !sda_lvl_reg &&
                     sda_prev_reg;
  assign stop_det = scl_lvl_reg && scl_prev_reg && sda_lvl_reg &&
                    !sda_prev_reg;
  assign ev8 = scl_fall && (bit_cnt_reg == bus_control_pkg::SLOT_DATA_END);
  assign ev9 = scl_fall && (bit_cnt_reg == bus_control_pkg::SLOT_ACK_END);

  // bit slot tracking; a condition restarts the first byte
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bit_cnt_reg <= 4'h0;
      first_byte_reg <= 1'b1;
      bus_busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      ack_slot_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start_det || stop_det)
      begin
        bit_cnt_reg <= 4'h0;
        first_byte_reg <= 1'b1;
        bus_busy_reg <= start_det;
        ack_slot_reg <= 1'b0;
      end
      else if (scl_rise)
      begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == bus_control_pkg::SLOT_DATA_END)
          nack_reg <= sda_lvl_reg;
      end
      else if (ev8)
        ack_slot_reg <= 1'b1;
      else if (ev9)
      begin
        bit_cnt_reg <= 4'h0;
        first_byte_reg <= 1'b0;
        ack_slot_reg <= 1'b0;
      end
    end
  end

  // fault window: slots one to nine of the first byte, two to nine of later bytes
  assign fault_set = cfg_reg.interface_on && bus_busy_reg &&
                     (start_det || stop_det) &&
                     (first_byte_reg ?
                      (bit_cnt_reg >= bus_control_pkg::SLOT_FAULT_FIRST_LO) :
                      (bit_cnt_reg >= bus_control_pkg::SLOT_FAULT_LO));

  // register writes
  assign rs_go = wr_ctl && wd[bus_control_pkg::B_ENGAGED] &&
                 wd[bus_control_pkg::B_CS] && cs_reg && engaged_reg;
  assign rs_clr = wr_ctl && wd[bus_control_pkg::B_ENGAGED] &&
                  engaged_reg;
  assign stop_go = wr_ctl && !wd[bus_control_pkg::B_CS] && cs_reg &&
                   engaged_reg && event_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      req_reg <= '0;
    else if (clk_en)
    begin
      req_reg.repeat_start_go <= rs_go;
      req_reg.stop_go <= stop_go;
    end
  end
  assign engine_req = req_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cfg_reg <= bus_control_pkg::RST_UNIT_CONFIG;
      ack_en_reg <= bus_control_pkg::RST_BUS_CONTROL[bus_control_pkg::B_ACK_EN];
      stall_reg <= bus_control_pkg::RST_BUS_CONTROL[bus_control_pkg::B_STALL];
      cond_en_reg <= bus_control_pkg::RST_BUS_CONTROL[bus_control_pkg::B_COND_EN];
      int_en_reg <= bus_control_pkg::RST_BUS_CONTROL[bus_control_pkg::B_INT_EN];
    end
    else if (clk_en)
    begin
      if (wr_cfg)
        cfg_reg <= wd[3:0];
      if (wr_ctl)
      begin
        ack_en_reg <= wd[bus_control_pkg::B_ACK_EN];
        stall_reg <= wd[bus_control_pkg::B_STALL];
        cond_en_reg <= wd[bus_control_pkg::B_COND_EN];
        int_en_reg <= wd[bus_control_pkg::B_INT_EN];
      end
    end
  end

  // controller select: software sets it, bus events drop it
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cs_reg <= bus_control_pkg::RST_BUS_CONTROL[bus_control_pkg::B_CS];
    else if (clk_en)
    begin
      if (!cfg_reg.interface_on || unit_status.arb_lost ||
          (fault_set && !cfg_reg.fault_hold_select))
        cs_reg <= 1'b0;
      else if (wr_ctl && wd[bus_control_pkg::B_CS])
        cs_reg <= 1'b1;
      else if (wr_ctl && (!engaged_reg || event_reg))
        cs_reg <= 1'b0;
    end
  end
  assign controller_select = cs_reg;

  assign reserved_first = first_byte_reg && unit_status.reserved_addr_seen;

  // engagement flag; sets win over bus clears, disable wins over all
  always_ff @(posedge clk)
  begin
    if (!nrst)
      engaged_reg <= bus_control_pkg::RST_BUS_CONTROL[bus_control_pkg::B_ENGAGED];
    else if (clk_en)
    begin
      if (!cfg_reg.interface_on)
        engaged_reg <= 1'b0;
      else if (unit_status.start_driven || unit_status.addr_match ||
               (ev9 && reserved_first && !nack_reg))
        engaged_reg <= 1'b1;
      else if (cs_reg && (stop_det || unit_status.arb_lost ||
               (fault_set && !cfg_reg.fault_hold_select)))
        engaged_reg <= 1'b0;
      else if (!cs_reg && (start_det || stop_det ||
               (ev9 && reserved_first && nack_reg) ||
               (fault_set && !cfg_reg.fault_hold_select)))
        engaged_reg <= 1'b0;
    end
  end

  // restart asked at slot eight stays pending until slot nine
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rs_pending_reg <= 1'b0;
    else if (clk_en)
    begin
      if (rs_go && ack_slot_reg && stall_reg)
        rs_pending_reg <= 1'b1;
      else if (ev9 || start_det || stop_det)
        rs_pending_reg <= 1'b0;
    end
  end

  // stall point: special cases fall back to the ninth bit
  assign stall_eff = stall_reg && !first_byte_reg &&
                     !(cfg_reg.rx_queue_on && nack_reg) &&
                     !unit_status.rx_queue_full;

  assign event_set = (engaged_reg && ev8 && (stall_eff || reserved_first)) ||
                     (engaged_reg && ev9 && !reserved_first &&
                      (!stall_eff || nack_reg)) ||
                     (engaged_reg && ev9 && rs_pending_reg && nack_reg) ||
                     (fault_set && !cfg_reg.fault_hold_select);
  assign event_clr = (wr_ctl && !wd[bus_control_pkg::B_EVENT]) || rs_clr ||
                     stop_go;

  // transfer event flag: set wins over a clearing write
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      event_reg <= bus_control_pkg::RST_BUS_CONTROL[bus_control_pkg::B_EVENT];
      event_by_fault_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (event_set)
      begin
        event_reg <= 1'b1;
        event_by_fault_reg <= fault_set && !cfg_reg.fault_hold_select;
      end
      else if (wr_ctl && wd[bus_control_pkg::B_EVENT] && cfg_reg.dma_mode &&
               !rs_clr && !stop_go)
        event_reg <= 1'b1;
      else if (event_clr)
      begin
        event_reg <= 1'b0;
        event_by_fault_reg <= 1'b0;
      end
    end
  end

  // condition flags: write zero clears, a new condition wins
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      stop_seen_reg <= bus_control_pkg::RST_COND_STATUS[bus_control_pkg::B_STOP_SEEN];
      rs_seen_reg <= bus_control_pkg::RST_COND_STATUS[bus_control_pkg::B_RS_SEEN];
    end
    else if (clk_en)
    begin
      if (stop_det && engaged_reg)
        stop_seen_reg <= 1'b1;
      else if (wr_stat && !wd[bus_control_pkg::B_STOP_SEEN])
        stop_seen_reg <= 1'b0;
      if (start_det && bus_busy_reg && engaged_reg)
        rs_seen_reg <= 1'b1;
      else if (wr_stat && !wd[bus_control_pkg::B_RS_SEEN])
        rs_seen_reg <= 1'b0;
    end
  end

  // bus fault flag
  always_ff @(posedge clk)
  begin
    if (!nrst)
      fault_reg <= bus_control_pkg::RST_BUS_CONTROL[bus_control_pkg::B_FAULT];
    else if (clk_en)
    begin
      if (!cfg_reg.interface_on)
        fault_reg <= 1'b0;
      else if (fault_set)
        fault_reg <= 1'b1;
      else if (!cfg_reg.fault_hold_select &&
               wr_ctl && !wd[bus_control_pkg::B_EVENT])
        fault_reg <= 1'b0;
      else if (cfg_reg.fault_hold_select &&
               ((wr_ctl && !wd[bus_control_pkg::B_EVENT] && event_reg) ||
                (wr_stat && !wd[bus_control_pkg::B_STOP_SEEN] &&
                 stop_seen_reg) ||
                (wr_stat && !wd[bus_control_pkg::B_RS_SEEN] && rs_seen_reg)))
        fault_reg <= 1'b0;
    end
  end

  // acknowledge decision for the ninth slot
  assign receiving = !unit_status.direction_is_send;
  always_comb
  begin
    ack_now = 1'b0;
    if (first_byte_reg && !unit_status.reserved_addr_seen)
      ack_now = 1'b0;
    else if (!unit_status.reserved_addr_seen &&
             unit_status.direction_is_send && !first_byte_reg)
      ack_now = 1'b0;
    else if (cfg_reg.rx_queue_on && !stall_reg && reserved_first &&
             unit_status.direction_is_send)
      ack_now = 1'b1;
    else if (cfg_reg.rx_queue_on && !cs_reg && receiving)
      ack_now = 1'b1;
    else if (cfg_reg.rx_queue_on && cs_reg && receiving && !stall_reg)
      ack_now = !unit_status.tx_holding_empty;
    else if (cfg_reg.rx_queue_on && cs_reg && receiving &&
             !unit_status.tx_holding_empty)
      ack_now = 1'b1;
    else
      ack_now = ack_en_reg;
  end

  // open-drain pins: only ever pull low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = ack_slot_reg && engaged_reg && ack_now;
  assign scl_oe = event_reg && !event_by_fault_reg;

  assign cond_irq = engaged_reg && cond_en_reg &&
                    (rs_seen_reg || stop_seen_reg);
  assign transfer_irq = event_reg && int_en_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_engage_on_start: assert property (
    clk_en && cfg_reg.interface_on && unit_status.start_driven
    |=> engaged_reg)
    else $error("start did not engage");
  a_master_stop_drop: assert property (
    clk_en && cfg_reg.interface_on && cs_reg && stop_det &&
    !unit_status.start_driven && !unit_status.addr_match |=> !engaged_reg)
    else $error("master stayed engaged after stop");
  a_slave_start_drop: assert property (
    clk_en && cfg_reg.interface_on && !cs_reg && start_det &&
    !unit_status.start_driven && !unit_status.addr_match |=> !engaged_reg)
    else $error("slave stayed engaged after start");
  a_restart_pulse: assert property (
    clk_en && wr_ctl && wd[bus_control_pkg::B_ENGAGED] &&
    wd[bus_control_pkg::B_CS] && cs_reg && engaged_reg
    |=> engine_req.repeat_start_go)
    else $error("restart write gave no request");
  a_restart_clears: assert property (
    clk_en && rs_clr && !event_set |=> !event_reg)
    else $error("restart write left event flag set");
  a_deselect_wins: assert property (
    clk_en && stop_go |=> engine_req.stop_go && !engine_req.repeat_start_go)
    else $error("deselect did not give stop alone");
  a_sda_only_slot: assert property (
    sda_oe |-> ack_slot_reg && !(!unit_status.reserved_addr_seen &&
    unit_status.direction_is_send && !first_byte_reg))
    else $error("sda driven outside receive ack slot");
  a_queue_slave_ack: assert property (
    ack_slot_reg && engaged_reg && cfg_reg.rx_queue_on && !cs_reg &&
    !first_byte_reg && !unit_status.direction_is_send |-> sda_oe)
    else $error("queued slave reception not acked");
  a_fault_sets: assert property (
    clk_en && fault_set |=> fault_reg)
    else $error("fault not flagged");
  a_fault_off: assert property (
    clk_en && !cfg_reg.interface_on |=> !fault_reg && !engaged_reg)
    else $error("disable left fault or engaged set");
  a_scl_hold: assert property (
    clk_en && event_set && !fault_set |=> scl_oe)
    else $error("scl not held for event");
  a_irq_gate: assert property (
    clk_en && event_set && int_en_reg && !wr_ctl |=> transfer_irq)
    else $error("enabled event gave no interrupt");

  c_restart: cover property (clk_en && rs_go);
  c_stop: cover property (clk_en && stop_go);
  c_fault: cover property (clk_en && fault_set);
  c_nack_restart: cover property (clk_en && ev9 && rs_pending_reg && nack_reg);
endmodule
`default_nettype wire

//--- rtl/bus_control_pkg.sv
// constants and carrier types for the bus control flag block
package bus_control_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_BUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COND_STATUS = 8'h04;
  localparam logic [7:0] OFF_UNIT_CONFIG = 8'h08;
  // bus_control field positions
  localparam int B_CS = 7;
  localparam int B_ENGAGED = 6;
  localparam int B_ACK_EN = 5;
  localparam int B_STALL = 4;
  localparam int B_COND_EN = 3;
  localparam int B_INT_EN = 2;
  localparam int B_FAULT = 1;
  localparam int B_EVENT = 0;
  // cond_status field positions
  localparam int B_STOP_SEEN = 0;
  localparam int B_RS_SEEN = 1;
  localparam int B_BUS_BUSY = 2;
  // unit_config field positions
  localparam int B_IFACE_ON = 0;
  localparam int B_HOLD_SEL = 1;
  localparam int B_RXQ_ON = 2;
  localparam int B_DMA = 3;
  // reset values
  localparam logic [7:0] RST_BUS_CONTROL = 8'h00;
  localparam logic [3:0] RST_UNIT_CONFIG = 4'h0;
  localparam logic [1:0] RST_COND_STATUS = 2'h0;
  // bit slot counts within a byte
  localparam logic [3:0] SLOT_DATA_END = 4'h8;
  localparam logic [3:0] SLOT_ACK_END = 4'h9;
  localparam logic [3:0] SLOT_FAULT_LO = 4'h2;
  localparam logic [3:0] SLOT_FAULT_FIRST_LO = 4'h1;
  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // settings that software keeps in unit_config
  typedef struct packed {
    logic dma_mode;
    logic rx_queue_on;
    logic fault_hold_select;
    logic interface_on;
  } unit_cfg_t;

  // status handed in by the rest of the serial unit
  typedef struct packed {
    logic start_driven;
    logic addr_match;
    logic arb_lost;
    logic reserved_addr_seen;
    logic direction_is_send;
    logic tx_holding_empty;
    logic rx_queue_full;
  } unit_status_t;

  // requests handed out to the bus engine
  typedef struct packed {
    logic repeat_start_go;
    logic stop_go;
  } engine_req_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10,
    PH_READ_OUT = 2'b11
  } bus_phase_t;
endpackage

//--- verif/i2c_peer.sv
// far-side bus peer: open-drain master framing bits on scl and sda
`timescale 1ns/1ps
`default_nettype none
module i2c_peer (
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  localparam realtime QTR = 31.25;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // pull-ups: a released line reads high, never the last value
  assign scl = ~(scl_low | scl_oe);
  assign sda = ~(sda_low | sda_oe);
  task automatic rise();
    int n;
    scl_low = 1'b0;
    // device may hold scl low; bounded so a stuck hold cannot hang us
    for (n = 0; n < 64 && scl !== 1'b1; n++)
      #(QTR);
    #(QTR);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #(QTR);
    rise();
    s = sda;
    #(QTR);
    scl_low = 1'b1;
    #(QTR);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic start();
    sda_low = 1'b1;
    #(QTR);
    scl_low = 1'b1;
    #(QTR);
  endtask
  task automatic rstart();
    sda_low = 1'b0;
    #(QTR);
    rise();
    start();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #(QTR);
    rise();
    sda_low = 1'b0;
    #(QTR);
  endtask
endmodule
`default_nettype wire

//--- verif/test_bus_control_flags.sv
// self-checking bench for the bus control flag block
`timescale 1ns/1ps
`default_nettype none
module test_bus_control_flags;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, scl_oe, sda_oe, scl, sda, csel, cirq, tirq, ack;
  logic [31:0] hrdata, q;
  bus_control_pkg::unit_status_t ust = '0;
  bus_control_pkg::engine_req_t ereq;
  logic [7:0] rnd = 8'h3f;
  logic cen = 1'b1;
  int err_total = 0;
  int n_checks = 0;
  int rs_cnt = 0;
  int sp_cnt = 0;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    rs_cnt <= rs_cnt + int'(ereq.repeat_start_go === 1'b1);
    sp_cnt <= sp_cnt + int'(ereq.stop_go === 1'b1);
  end
  bus_control_flags i_bus_control_flags (.clk(clk), .nrst(nrst),
    .clk_en(cen), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_in(scl),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .unit_status(ust), .engine_req(ereq), .controller_select(csel),
    .cond_irq(cirq), .transfer_irq(tirq));
  i2c_peer i_i2c_peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // idle slave: only the enables read back, flags stay clear
  function automatic logic [31:0] ctl_exp(input logic [7:0] v);
    return {24'h0, v & 8'h3c};
  endfunction
  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wait_rdy(inout int n);
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(n);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_rdy(n);
    q = hrdata;
    if (n >= 20)
      err_total++;
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
    input logic [31:0] e, input logic [7:0] m);
    xfer(a, 1'b0, 8'h00);
    chk(what, e, q & {24'hffffff, m});
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge clk);
    ust <= bus_control_pkg::unit_status_t'(v);
    @(posedge clk);
    ust <= '0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    rdc("bus_control", 8'h00, 32'h0, 8'hff);
    rdc("unmapped", 8'h0c, 32'h0, 8'hff);
    chk("hresp", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      xfer(8'h00, 1'b1, rnd & 8'h7f);
      rdc("enables", 8'h00, ctl_exp(rnd), 8'hff);
    end
    // slave reception: ack enabled, disabled, then receive queue on
    xfer(8'h08, 1'b1, 8'h01);
    i_i2c_peer.start();
    i_i2c_peer.send(8'ha0, ack);
    // a match while frozen must be lost
    cen <= 1'b0;
    pulse(7'h20);
    cen <= 1'b1;
    rdc("frozen", 8'h00, 32'h0, 8'h40);
    pulse(7'h20);
    rdc("slave engaged", 8'h00, 32'h40, 8'h40);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        xfer(8'h08, 1'b1, 8'h05);
      xfer(8'h00, 1'b1, k ? 8'h00 : 8'h24);
      rnd = lfsr(rnd);
      i_i2c_peer.send(rnd, ack);
      chk("ack slot", {31'h0, k == 1}, {31'h0, ack});
      repeat (8) @(posedge clk);
      chk("scl hold", 32'h1, {31'h0, scl_oe});
      chk("transfer irq", {31'h0, k == 0}, {31'h0, tirq});
    end
    xfer(8'h00, 1'b1, 8'h00);
    @(posedge clk);
    chk("scl free", 32'h0, {31'h0, scl_oe});
    i_i2c_peer.stop();
    rdc("slave stop", 8'h00, 32'h0, 8'h40);
    rdc("stop seen", 8'h04, 32'h1, 8'h01);
    // master with dma: condition irq, restart, deselect priority
    xfer(8'h08, 1'b1, 8'h09);
    xfer(8'h00, 1'b1, 8'h88);
    i_i2c_peer.start();
    pulse(7'h40);
    i_i2c_peer.send(8'ha0, ack);
    xfer(8'h00, 1'b1, 8'h88);
    i_i2c_peer.rstart();
    repeat (8) @(posedge clk);
    chk("cond irq", 32'h1, {31'h0, cirq});
    xfer(8'h04, 1'b1, 8'h00);
    xfer(8'h00, 1'b1, 8'h89);
    rdc("event set", 8'h00, 32'h1, 8'h01);
    xfer(8'h00, 1'b1, 8'hc9);
    rdc("restart", 8'h00, 32'hc8, 8'hc9);
    xfer(8'h00, 1'b1, 8'h89);
    xfer(8'h00, 1'b1, 8'h41);
    // counters take one more edge to record the pulse
    repeat (2) @(posedge clk);
    chk("restart pulses", 1, rs_cnt);
    chk("stop pulses", 1, sp_cnt);
    chk("controller select", 0, {31'h0, csel});
    xfer(8'h00, 1'b1, 8'h88);
    pulse(7'h10);
    rdc("arbitration loss", 8'h00, 32'h0, 8'h40);
    i_i2c_peer.stop();
    // stop right after a restart lands inside the first byte
    rdc("stop fault", 8'h00, 32'h03, 8'h43);
    xfer(8'h08, 1'b1, 8'h00);
    rdc("interface off", 8'h00, 32'h01, 8'h43);
    // slave with a start inside the second byte
    xfer(8'h08, 1'b1, 8'h01);
    xfer(8'h00, 1'b1, 8'h04);
    i_i2c_peer.start();
    i_i2c_peer.send(8'ha0, ack);
    pulse(7'h20);
    xfer(8'h00, 1'b1, 8'h04);
    for (int i = 0; i < 3; i++)
      i_i2c_peer.bit_io(i[0], ack);
    i_i2c_peer.rstart();
    repeat (8) @(posedge clk);
    rdc("bus fault", 8'h00, 32'h03, 8'h43);
    xfer(8'h00, 1'b1, 8'h04);
    rdc("fault clear", 8'h00, 32'h0, 8'h02);
    summarize();
  end
endmodule
`default_nettype wire
